/* File: logic/tcm_top.sv */
// Top of the 8-bit timer compare block: counter, compare, flags, output.
// Assumes a synchronous register master on ref_clk; port value and
// direction come from registers here, the pin is driven by oc_pin_out.
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/10ps
module tcm_top
    import tcm_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    // Register port
    input  wire logic [TCM_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [7:0]                 reg_rdata,
    // Interrupt acknowledges from the CPU
    input  wire logic                  cmp_irq_ack,
    input  wire logic                  ovf_irq_ack,
    // Interrupt requests
    output logic                       cmp_irq_req,
    output logic                       ovf_irq_req,
    // Output pin
    output logic                       oc_pin_out,
    output logic                       oc_pin_oe_n
);
    import tcm_pkg::*;

    //--------------------------------------------------------------------
    // State
    //--------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] cs;
        logic [1:0] wgm;
        logic [1:0] com;
        logic [7:0] cnt;
        logic [7:0] ocr;
        logic [7:0] ocr_buf;
        logic       blk;
        logic       match_d;
        logic       ocf;
        logic       tov;
        logic       ocie;
        logic       toie;
        logic       port_val;
        logic       port_dir;
        logic       oc;
        logic       down;
        logic [7:0] rdata;
        logic       cmp_req;
        logic       ovf_req;
        logic       pin;
        logic       pin_oe_n;
    } tcm_st_type;

    tcm_st_type st_ff;
    tcm_st_type s;

    tcm_tick_if tk ();

    //--------------------------------------------------------------------
    // Clock select and comparator
    //--------------------------------------------------------------------
    tcm_clk_sel u_clk_sel (
        .ref_clk             (ref_clk),
        .rst_n               (rst_n),
        .clock_source_select (st_ff.cs),
        .tk                  (tk.src)
    );

    assign tk.count = st_ff.cnt;
    assign tk.ocr   = st_ff.ocr;
    assign tk.blk   = st_ff.blk;

    // PWM modes use the double buffer
    function automatic logic is_pwm(input logic [1:0] w);
        is_pwm = (w == WGM_PC_PWM) || (w == WGM_FASTPWM);
    endfunction : is_pwm

    // Output state after a match in non-PWM modes
    function automatic logic act(input logic [1:0] c, input logic o);
        unique case (c)
            COM_NONE:   act = o;
            COM_TOGGLE: act = ~o;
            COM_CLEAR:  act = 1'b0;
            COM_SET:    act = 1'b1;
        endcase
    endfunction : act

    logic wr_ctrl;
    logic wr_cnt;
    logic wr_cmp;
    logic wr_flag;
    logic m_tick;

    assign wr_ctrl = reg_wr && (reg_addr == TCM_ADDR_CTRL);
    assign wr_cnt  = reg_wr && (reg_addr == TCM_ADDR_COUNT);
    assign wr_cmp  = reg_wr && (reg_addr == TCM_ADDR_CMP);
    assign wr_flag = reg_wr && (reg_addr == TCM_ADDR_FLAGS);
    assign m_tick  = tk.tick && tk.match;

    //--------------------------------------------------------------------
    // Next-state logic
    //--------------------------------------------------------------------
    always_comb begin
        s = st_ff;

        // Control register; action bits take effect at once
        if (wr_ctrl) begin
            s.cs  = reg_wdata[CTRL_CS_LSB +: 3];
            s.wgm = reg_wdata[CTRL_WGM_LSB +: 2];
            s.com = reg_wdata[CTRL_COM_LSB +: 2];
        end
        if (reg_wr && (reg_addr == TCM_ADDR_IRQEN)) begin
            s.toie = reg_wdata[FLAG_OVF_BIT];
            s.ocie = reg_wdata[FLAG_CMP_BIT];
        end
        if (reg_wr && (reg_addr == TCM_ADDR_PORT)) begin
            s.port_val = reg_wdata[PORT_VAL_BIT];
            s.port_dir = reg_wdata[PORT_DIR_BIT];
        end

        // Compare register: buffer in PWM, direct otherwise
        if (wr_cmp) begin
            if (is_pwm(st_ff.wgm)) begin
                s.ocr_buf = reg_wdata;
            end else begin
                s.ocr     = reg_wdata;
                s.ocr_buf = reg_wdata;
            end
        end

        // Counter write blocks matches at the next timer tick only
        if (wr_cnt) begin
            s.blk = 1'b1;
        end else if (tk.tick) begin
            s.blk = 1'b0;
        end

        // Counter sequence; a CPU write has priority
        if (wr_cnt) begin
            s.cnt = reg_wdata;
        end else if (tk.tick) begin
            unique case (st_ff.wgm)
                WGM_NORMAL: begin
                    s.cnt = st_ff.cnt + 8'h01;
                end
                WGM_CLR: begin
                    if (tk.match) begin
                        s.cnt = CNT_BOTTOM;
                    end else begin
                        s.cnt = st_ff.cnt + 8'h01;
                    end
                end
                WGM_FASTPWM: begin
                    s.cnt = st_ff.cnt + 8'h01;
                end
                WGM_PC_PWM: begin
                    if (st_ff.cnt == CNT_MAX) begin
                        s.down = 1'b1;
                        s.cnt  = st_ff.cnt - 8'h01;
                    end else if (st_ff.cnt == CNT_BOTTOM) begin
                        s.down = 1'b0;
                        s.cnt  = st_ff.cnt + 8'h01;
                    end else if (st_ff.down) begin
                        s.cnt = st_ff.cnt - 8'h01;
                    end else begin
                        s.cnt = st_ff.cnt + 8'h01;
                    end
                end
            endcase
        end

        // Double buffer update at the top (CNT_MAX) in both PWM modes
        if (tk.tick && is_pwm(st_ff.wgm)) begin
            if ((st_ff.wgm == WGM_FASTPWM && st_ff.cnt == CNT_MAX) ||
                (st_ff.wgm == WGM_PC_PWM && st_ff.cnt == CNT_MAX)) begin
                s.ocr = st_ff.ocr_buf;
            end
        end

        // Overflow flag on max-to-zero step in non-PWM modes only, set wins
        if ((ovf_irq_ack || (wr_flag && reg_wdata[FLAG_OVF_BIT]))) begin
            s.tov = 1'b0;
        end
        if (!wr_cnt && tk.tick && st_ff.cnt == CNT_MAX &&
            !is_pwm(st_ff.wgm)) begin
            s.tov = 1'b1;
        end

        // Compare flag one tick after the match, set wins
        s.match_d = tk.tick ? tk.match : st_ff.match_d;
        if (cmp_irq_ack || (wr_flag && reg_wdata[FLAG_CMP_BIT])) begin
            s.ocf = 1'b0;
        end
        if (tk.tick && st_ff.match_d) begin
            s.ocf = 1'b1;
        end

        // Output state: real match or forced strobe; kept on mode change
        if (!is_pwm(st_ff.wgm)) begin
            if (wr_ctrl && reg_wdata[CTRL_FOC_BIT] && !is_pwm(reg_wdata[CTRL_WGM_LSB +: 2])) begin
                s.oc = act(s.com, st_ff.oc);
            end else if (m_tick) begin
                s.oc = act(st_ff.com, st_ff.oc);
            end
        end else if (m_tick && st_ff.com[1]) begin
            // PWM modes: clear on up-match, set on down-match (inverted by com[0])
            s.oc = st_ff.down ^ st_ff.com[0];
        end

        // Pin: output state overrides port value when action nonzero
        s.pin      = (s.com != COM_NONE) ? s.oc : s.port_val;
        s.pin_oe_n = ~s.port_dir;

        // Requests
        s.cmp_req = s.ocf && s.ocie;
        s.ovf_req = s.tov && s.toie;

        // Read data in the cycle after the strobe
        s.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                TCM_ADDR_CTRL:   s.rdata = {1'b0, st_ff.com, st_ff.wgm, st_ff.cs};
                TCM_ADDR_COUNT:  s.rdata = st_ff.cnt;
                TCM_ADDR_CMP:    s.rdata = is_pwm(st_ff.wgm) ? st_ff.ocr_buf : st_ff.ocr;
                TCM_ADDR_FLAGS:  s.rdata = {6'h00, st_ff.ocf, st_ff.tov};
                TCM_ADDR_IRQEN:  s.rdata = {6'h00, st_ff.ocie, st_ff.toie};
                TCM_ADDR_PORT:   s.rdata = {6'h00, st_ff.port_dir, st_ff.port_val};
                TCM_ADDR_STATUS: s.rdata = {6'h00, st_ff.down, st_ff.oc};
                default:         s.rdata = 8'h00;
            endcase
        end
    end

    //--------------------------------------------------------------------
    // State register
    //--------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff          <= '0;
            st_ff.pin_oe_n <= 1'b1;
        end else begin
            st_ff <= s;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata   = st_ff.rdata;
    assign cmp_irq_req = st_ff.cmp_req;
    assign ovf_irq_req = st_ff.ovf_req;
    assign oc_pin_out  = st_ff.pin;
    assign oc_pin_oe_n = st_ff.pin_oe_n;

endmodule : tcm_top

/* File: logic/tcm_pkg.sv */
// Package for the 8-bit timer compare block: normal, clear-on-match and PWM modes.
// Assumes a single 50 MHz clock and a plain register port on the top module.
package tcm_pkg;

    // Register indices (byte address is index times four)
    localparam logic [3:0] TCM_ADDR_CTRL   = 4'h0;
    localparam logic [3:0] TCM_ADDR_COUNT  = 4'h1;
    localparam logic [3:0] TCM_ADDR_CMP    = 4'h2;
    localparam logic [3:0] TCM_ADDR_FLAGS  = 4'h3;
    localparam logic [3:0] TCM_ADDR_IRQEN  = 4'h4;
    localparam logic [3:0] TCM_ADDR_PORT   = 4'h5;
    localparam logic [3:0] TCM_ADDR_STATUS = 4'h6;
    localparam int         TCM_ADDR_W      = 4;

    // Control register field positions
    localparam int CTRL_CS_LSB  = 0;
    localparam int CTRL_WGM_LSB = 3;
    localparam int CTRL_COM_LSB = 5;
    localparam int CTRL_FOC_BIT = 7;
    // Flag / enable positions
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_CMP_BIT = 1;
    // Port register positions
    localparam int PORT_VAL_BIT = 0;
    localparam int PORT_DIR_BIT = 1;

    // Waveform modes
    localparam logic [1:0] WGM_NORMAL  = 2'h0;
    localparam logic [1:0] WGM_PC_PWM  = 2'h1;
    localparam logic [1:0] WGM_CLR     = 2'h2;
    localparam logic [1:0] WGM_FASTPWM = 2'h3;

    // Output actions in non-PWM modes
    localparam logic [1:0] COM_NONE   = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    // Counter limits and reset values
    localparam logic [7:0] CNT_MAX    = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] RST_BYTE   = 8'h00;

    // Prescaler taps, clock select 1..7
    localparam int PRE_MAX = 1024;
    localparam int PRE_W   = 10;

    typedef logic [7:0] tcm_byte_type;

endpackage : tcm_pkg

/* File: logic/tcm_tick_if.sv */
// Interface carrying the timer tick and counter view between modules.
// Assumes all members change on ref_clk.
`timescale 1ns/10ps
interface tcm_tick_if;
    logic       tick;     // Timer clock enable
    logic [7:0] count;    // Current counter value
    logic [7:0] ocr;      // Active compare value
    logic       blk;      // Compare block after counter write
    logic       match;    // Comparator result

    modport src  (output tick, input count, input ocr, input blk, output match);
    modport core (input tick, output count, output ocr, output blk, input match);
endinterface : tcm_tick_if

/* File: logic/tcm_clk_sel.sv */
// Timer clock enable generator and comparator.
// Assumes clock select held in the main module; ticks come every ref_clk cycle only with clock select 1.
`timescale 1ns/10ps
module tcm_clk_sel
    import tcm_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Clock select field
    input  wire logic [2:0] clock_source_select,
    // Tick and compare carrier
    tcm_tick_if.src         tk
);
    import tcm_pkg::*;

    typedef struct packed {
        logic [PRE_W-1:0] pre;
        logic             tick;
    } tcm_cs_type;

    tcm_cs_type st_ff;
    tcm_cs_type nxt_st;

    // Prescaler tap select; zero stops the timer clock
    function automatic logic tap(input logic [2:0] cs, input logic [PRE_W-1:0] p);
        unique case (cs)
            3'h0: tap = 1'b0;
            3'h1: tap = 1'b1;
            3'h2: tap = (p[2:0] == 3'h7);
            3'h3: tap = (p[4:0] == 5'h1f);
            3'h4: tap = (p[5:0] == 6'h3f);
            3'h5: tap = (p[6:0] == 7'h7f);
            3'h6: tap = (p[7:0] == 8'hff);
            3'h7: tap = (p == {PRE_W{1'b1}});
        endcase
    endfunction : tap

    // Next prescaler and tick
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.pre  = st_ff.pre + 1'b1;
        nxt_st.tick = tap(clock_source_select, st_ff.pre);
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tk.tick  = st_ff.tick;
    // Comparator, blocked after a counter write
    assign tk.match = (tk.count == tk.ocr) && !tk.blk;

endmodule : tcm_clk_sel

/* File: sim/tcm_monitor.sv */
// Port-level checker for tcm_top, bound to every instance of it.
// Assumes register writes are taken on the ref_clk edge with reg_wr high.
`timescale 1ns/10ps
module tcm_monitor
    import tcm_pkg::*;
(
    // Clock and reset
    input wire logic                  ref_clk,
    input wire logic                  rst_n,
    // Register port
    input wire logic [TCM_ADDR_W-1:0] reg_addr,
    input wire logic [7:0]            reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [7:0]            reg_rdata,
    // Interrupts
    input wire logic                  cmp_irq_ack,
    input wire logic                  ovf_irq_ack,
    input wire logic                  cmp_irq_req,
    input wire logic                  ovf_irq_req,
    // Pin
    input wire logic                  oc_pin_out,
    input wire logic                  oc_pin_oe_n
);
    // ------------------------------------------------------------
    // Shadows of written control fields
    // ------------------------------------------------------------
    logic [7:0] ctrl_ff;
    logic [1:0] port_ff;
    logic [1:0] en_ff;
    wire logic  stop = (ctrl_ff[2:0] == 3'h0);

    // Track software writes the same way the block takes them
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= 8'h00;
            port_ff <= 2'h0;
            en_ff   <= 2'h0;
        end else if (reg_wr) begin
            if (reg_addr == TCM_ADDR_CTRL) ctrl_ff <= reg_wdata;
            if (reg_addr == TCM_ADDR_PORT) port_ff <= reg_wdata[1:0];
            if (reg_addr == TCM_ADDR_IRQEN) en_ff <= reg_wdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_dir_follow: assert property (
        reg_wr && reg_addr == TCM_ADDR_PORT |=> oc_pin_oe_n == !$past(reg_wdata[PORT_DIR_BIT]))
        else $error("pin enable does not follow direction bit");
    a_port_value: assert property (
        ctrl_ff[6:5] == COM_NONE |-> oc_pin_out == port_ff[PORT_VAL_BIT])
        else $error("pin does not show port value with action zero");
    a_cmp_ack: assert property (
        cmp_irq_ack && stop && $past(stop, 3) |-> ##2 !cmp_irq_req)
        else $error("compare request kept after acknowledge");
    a_ovf_ack: assert property (
        ovf_irq_ack && stop && $past(stop, 3) |-> ##2 !ovf_irq_req)
        else $error("overflow request kept after acknowledge");
    a_flag_wclr: assert property (
        reg_wr && reg_addr == TCM_ADDR_FLAGS && reg_wdata[1:0] == 2'h3 && stop
        && $past(stop, 3) |-> ##2 !cmp_irq_req && !ovf_irq_req)
        else $error("flag write of one did not clear");
    a_force_level: assert property (
        reg_wr && reg_addr == TCM_ADDR_CTRL && reg_wdata[CTRL_FOC_BIT] && reg_wdata[6]
        && !reg_wdata[3] |-> ##2 oc_pin_out == $past(reg_wdata[5], 2))
        else $error("forced set or clear not seen on pin");
    a_stop_still: assert property (
        stop && $past(stop, 3) && ctrl_ff[6:5] == COM_TOGGLE && !$past(reg_wr)
        && !$past(reg_wr, 2) |-> $stable(oc_pin_out))
        else $error("output toggled while timer stopped");
    a_cmp_gate: assert property (
        !en_ff[FLAG_CMP_BIT] && !$past(en_ff[FLAG_CMP_BIT]) && !$past(en_ff[FLAG_CMP_BIT], 2)
        |-> !cmp_irq_req)
        else $error("compare request while disabled");

    c_toggle: cover property (ctrl_ff[6:5] == COM_TOGGLE && $changed(oc_pin_out));
    c_ovf: cover property ($rose(ovf_irq_req));
    c_cmp: cover property ($rose(cmp_irq_req));
endmodule : tcm_monitor

bind tcm_top tcm_monitor u_mon (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmp_irq_ack(cmp_irq_ack), .ovf_irq_ack(ovf_irq_ack), .cmp_irq_req(cmp_irq_req),
    .ovf_irq_req(ovf_irq_req), .oc_pin_out(oc_pin_out), .oc_pin_oe_n(oc_pin_oe_n));

/* File: sim/tb_top.sv */
// Self-checking bench for tcm_top: reset, force table, count modes.
// Assumes tcm_monitor is compiled first and bound to the design.
`timescale 1ns/10ps
module tb_top;
    import tcm_pkg::*;
    // ------------------------------------------------------------
    // Signals and bookkeeping
    // ------------------------------------------------------------
    logic                  ref_clk     = 1'b0;
    logic                  rst_n       = 1'b0;
    logic [TCM_ADDR_W-1:0] reg_addr    = 4'h0;
    logic [7:0]            reg_wdata   = 8'h00;
    logic                  reg_wr      = 1'b0;
    logic                  reg_rd      = 1'b0;
    logic                  cmp_irq_ack = 1'b0;
    logic                  ovf_irq_ack = 1'b0;
    logic [7:0]            reg_rdata;
    logic                  cmp_irq_req, ovf_irq_req, oc_pin_out, oc_pin_oe_n;
    int                    mismatches  = 0;
    int                    tests_run   = 0;
    int                    cycles      = 0;
    int                    n;
    logic [7:0]            rv;
    logic                  pin_was;
    // Force rows: action written with the strobe, expected output state
    logic [1:0] act_tab [7] = '{2'h3, 2'h1, 2'h1, 2'h2, 2'h0, 2'h3, 2'h0};
    logic       exp_tab [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

    tcm_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_irq_ack(cmp_irq_ack),
        .ovf_irq_ack(ovf_irq_ack), .cmp_irq_req(cmp_irq_req), .ovf_irq_req(ovf_irq_req),
        .oc_pin_out(oc_pin_out), .oc_pin_oe_n(oc_pin_oe_n));

    // 50 MHz clock and a cycle ceiling against hangs
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(string name, logic [7:0] got, logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic ack(logic cmp);
        @(posedge ref_clk);
        cmp_irq_ack <= cmp;
        ovf_irq_ack <= !cmp;
        @(posedge ref_clk);
        cmp_irq_ack <= 1'b0;
        ovf_irq_ack <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : ack

    // Wait for a request, bounded
    task automatic wait_req(logic cmp, int lim);
        n = 0;
        #1;
        while ((cmp ? cmp_irq_req : ovf_irq_req) !== 1'b1 && n < lim) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask : wait_req

    // Cycles between the first and second pin changes seen from now
    task automatic pin_gap();
        for (int k = 0; k < 2; k++) begin
            n = 0;
            pin_was = oc_pin_out;
            while (oc_pin_out === pin_was && n < 600) begin
                @(posedge ref_clk);
                #1;
                n++;
            end
        end
    endtask : pin_gap

    task automatic give_verdict();
        $display("counts: %0d checks, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        wr(4'h7, 8'h5a);
        for (int a = 0; a < 8; a++) begin
            rd(4'(a), rv);
            chk("reset register", rv, 8'h00);
        end
        chk("reset oe_n", {7'h0, oc_pin_oe_n}, 8'h01);
        $display("test reset done");
        // Force table with timer stopped, port value 1, pin not yet driven
        wr(TCM_ADDR_PORT, 8'h01);
        for (int i = 0; i < 7; i++) begin
            wr(TCM_ADDR_CTRL, {1'b1, act_tab[i], WGM_NORMAL, 3'h0});
            rd(TCM_ADDR_STATUS, rv);
            chk("force state", {7'h0, rv[0]}, {7'h0, exp_tab[i]});
            chk("pin", {7'h0, oc_pin_out}, {7'h0, act_tab[i] != 0 ? exp_tab[i] : 1'b1});
        end
        wr(TCM_ADDR_PORT, 8'h03);
        chk("oe_n", {7'h0, oc_pin_oe_n}, 8'h00);
        rd(TCM_ADDR_FLAGS, rv);
        chk("flags after force", rv, 8'h00);
        wr(TCM_ADDR_CTRL, {1'b0, COM_NONE, WGM_CLR, 3'h0});
        rd(TCM_ADDR_STATUS, rv);
        chk("state over mode change", {7'h0, rv[0]}, 8'h01);
        $display("test force done");
        // Normal mode through the top of the count
        wr(TCM_ADDR_CMP, 8'h80);
        wr(TCM_ADDR_COUNT, 8'hfc);
        wr(TCM_ADDR_IRQEN, 8'h01);
        wr(TCM_ADDR_CTRL, {1'b0, COM_NONE, WGM_NORMAL, 3'h1});
        wait_req(1'b0, 20);
        wr(TCM_ADDR_CTRL, 8'h00);
        rd(TCM_ADDR_FLAGS, rv);
        chk("flags after wrap", rv, 8'h01);
        rd(TCM_ADDR_COUNT, rv);
        chk("count wrapped", {7'h0, rv < 8'h10}, 8'h01);
        ack(1'b0);
        chk("overflow request", {7'h0, ovf_irq_req}, 8'h00);
        $display("test normal done");
        // Clear-on-match toggle, compare 3, prescale 1
        wr(TCM_ADDR_COUNT, 8'h00);
        wr(TCM_ADDR_CMP, 8'h03);
        wr(TCM_ADDR_IRQEN, 8'h02);
        wr(TCM_ADDR_CTRL, {1'b0, COM_TOGGLE, WGM_CLR, 3'h1});
        pin_gap();
        chk("toggle gap", 8'(n), 8'h04);
        chk("compare request", {7'h0, cmp_irq_req}, 8'h01);
        wr(TCM_ADDR_CTRL, {1'b0, COM_CLEAR, WGM_CLR, 3'h1});
        repeat (8) @(posedge ref_clk);
        #1;
        chk("action clear", {7'h0, oc_pin_out}, 8'h00);
        wr(TCM_ADDR_CTRL, {1'b0, COM_SET, WGM_CLR, 3'h1});
        repeat (8) @(posedge ref_clk);
        #1;
        chk("action set", {7'h0, oc_pin_out}, 8'h01);
        wr(TCM_ADDR_CTRL, {1'b0, COM_TOGGLE, WGM_CLR, 3'h0});
        repeat (4) @(posedge ref_clk);
        #1;
        pin_was = oc_pin_out;
        wr(TCM_ADDR_COUNT, 8'h42);
        rd(TCM_ADDR_COUNT, rv);
        chk("count while stopped", rv, 8'h42);
        chk("pin while stopped", {7'h0, oc_pin_out}, {7'h0, pin_was});
        ack(1'b1);
        chk("compare request", {7'h0, cmp_irq_req}, 8'h00);
        $display("test clear-on-match done");
        // Counter write equal to compare hides that match
        wr(TCM_ADDR_CMP, 8'h42);
        wr(TCM_ADDR_COUNT, 8'h42);
        wr(TCM_ADDR_CTRL, {1'b0, COM_NONE, WGM_CLR, 3'h1});
        wr(TCM_ADDR_CTRL, {1'b0, COM_NONE, WGM_CLR, 3'h0});
        rd(TCM_ADDR_FLAGS, rv);
        chk("blocked match flag", rv, 8'h00);
        rd(TCM_ADDR_COUNT, rv);
        chk("count not cleared", {7'h0, rv > 8'h42}, 8'h01);
        // Compare now below the count: match waits for the wrap
        wr(TCM_ADDR_CTRL, {1'b0, COM_NONE, WGM_CLR, 3'h1});
        repeat (20) @(posedge ref_clk);
        rd(TCM_ADDR_FLAGS, rv);
        chk("no early match", rv, 8'h00);
        wait_req(1'b1, 400);
        chk("match after wrap", {7'h0, cmp_irq_req}, 8'h01);
        wr(TCM_ADDR_CTRL, 8'h00);
        repeat (4) @(posedge ref_clk);
        wr(TCM_ADDR_FLAGS, 8'h03);
        rd(TCM_ADDR_FLAGS, rv);
        chk("flags cleared by write", rv, 8'h00);
        $display("test blocking and wrap done");
        // PWM modes: compare writes land in the buffer until the top
        wr(TCM_ADDR_CMP, 8'h10);
        wr(TCM_ADDR_COUNT, 8'h0e);
        wr(TCM_ADDR_CTRL, {1'b0, COM_NONE, WGM_PC_PWM, 3'h0});
        wr(TCM_ADDR_CMP, 8'h20);
        rd(TCM_ADDR_CMP, rv);
        chk("buffered compare", rv, 8'h20);
        wr(TCM_ADDR_CTRL, {1'b0, COM_NONE, WGM_FASTPWM, 3'h1});
        repeat (8) @(posedge ref_clk);
        wr(TCM_ADDR_CTRL, 8'h00);
        rd(TCM_ADDR_FLAGS, rv);
        chk("old compare still active", rv, 8'h02);
        $display("test compare buffer done");
        give_verdict();
    end
endmodule : tb_top
